// ==== verilog/sbsram_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Selected only with all three enables asserted
// - Full write on global or all lanes
// - Bus stays undriven after write until strobe
// - Idle advance input holds burst address
// - Burst wraps to first captured address
// - Data driven only after output drive sampled low at a clock edge
module sbsram_ctrl
  import sbsram_pkg::*;
#(
  parameter int AW           = ADDR_W,
  parameter int DW           = DATA_W,
  parameter int NB           = LANES,
  parameter int POWER_UP_CYC = sbsram_pkg::POWER_UP_CYC
) (
  input  wire logic          mclk_i,
  input  wire logic          rst_n_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic          cpu_addr_strobe_n_i,
  input  wire logic          ctrl_addr_strobe_n_i,
  input  wire logic          burst_step_n_i,
  input  wire logic          burst_interleave_i,
  input  wire logic          select_primary_n_i,
  input  wire logic          select_high_depth_i,
  input  wire logic          select_low_depth_n_i,
  input  wire logic          global_write_n_i,
  input  wire logic          byte_write_gate_n_i,
  input  wire logic [NB-1:0] byte_lane_write_n_i,
  input  wire logic          output_drive_n_i,
  input  wire logic [DW-1:0] data_i,
  output var  logic [DW-1:0] data_o,
  output var  logic          data_oe_n_o
);
  localparam int PW = $clog2(POWER_UP_CYC + 1);
  localparam logic [PW-1:0] PWR_LAST = PW'(POWER_UP_CYC - 1);

  typedef struct packed {
    sbsram_state_e        st;
    logic                 rd_ok;
    logic                 interleave;
    logic [BURST_W-1:0]   cnt;
    logic [BURST_W-1:0]   base_lo;
    logic [AW-BURST_W-1:0] hi;
    logic                 oe_n;
    logic [PW-1:0]        pwr_cnt;
    logic                 pwr_ok;
  } sbsram_reg_s;

  localparam sbsram_reg_s RESET_VAL = '{
    st: SBS_IDLE, rd_ok: 1'b0, interleave: 1'b0, cnt: BURST_ZERO,
    base_lo: BURST_ZERO, hi: '0, oe_n: 1'b1, pwr_cnt: '0, pwr_ok: 1'b0
  };

  sbsram_reg_s r;
  sbsram_reg_s next_r;

  logic          sel;
  logic          cpu_start;
  logic          ctrl_start;
  logic          start;
  logic          wr_req;
  logic [NB-1:0] wr_lanes;
  logic [NB-1:0] lane_we;
  logic [BURST_W-1:0] acc_lo;
  logic [AW-1:0] acc_addr;

  always_comb begin
    sel = !select_primary_n_i && select_high_depth_i && !select_low_depth_n_i;
    // Processor strobe is gated by the primary enable alone
    cpu_start  = !cpu_addr_strobe_n_i && !select_primary_n_i;
    ctrl_start = !ctrl_addr_strobe_n_i && !cpu_start;
    start      = r.pwr_ok && (cpu_start || ctrl_start);
    if (!global_write_n_i) begin
      wr_lanes = '1;
    end else if (!byte_write_gate_n_i) begin
      wr_lanes = ~byte_lane_write_n_i;
    end else begin
      wr_lanes = '0;
    end
    wr_req = wr_lanes != '0;

    next_r = r;
    if (!r.pwr_ok) begin
      // Accesses before the power-up wait are ignored
      next_r.pwr_cnt = PW'(r.pwr_cnt + 1'b1);
      next_r.pwr_ok  = r.pwr_cnt == PWR_LAST;
    end
    if (start) begin
      if (sel) begin
        next_r.hi         = addr_i[AW-1:BURST_W];
        next_r.base_lo    = addr_i[BURST_W-1:0];
        next_r.cnt        = BURST_ZERO;
        next_r.interleave = burst_interleave_i;
        // Write controls are ignored in a processor strobe cycle
        if (cpu_start || !wr_req) begin
          next_r.st    = SBS_READ;
          next_r.rd_ok = 1'b1;
        end else begin
          next_r.st    = SBS_WRITE;
          next_r.rd_ok = 1'b0;
        end
      end else begin
        next_r.st    = SBS_IDLE;
        next_r.rd_ok = 1'b0;
      end
    end else if (r.pwr_ok && r.st != SBS_IDLE) begin
      if (!burst_step_n_i) begin
        // Two-bit counter wraps past the fourth word
        next_r.cnt = BURST_W'(r.cnt + 1'b1);
      end
      if (wr_req) begin
        next_r.st    = SBS_WRITE;
        next_r.rd_ok = 1'b0;
      end else begin
        next_r.st = SBS_READ;
      end
    end
    // Pin enable follows drive input one edge late; inputs are synchronous
    next_r.oe_n = !(next_r.st == SBS_READ && next_r.rd_ok && !output_drive_n_i);

    if (next_r.interleave) begin
      acc_lo = next_r.base_lo ^ next_r.cnt;
    end else begin
      acc_lo = BURST_W'(next_r.base_lo + next_r.cnt);
    end
    acc_addr = {next_r.hi, acc_lo};
    lane_we  = (next_r.st == SBS_WRITE) ? wr_lanes : '0;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= RESET_VAL;
    end else begin
      r <= next_r;
    end
  end

  assign data_oe_n_o = r.oe_n;

  sbsram_mem #(
    .AW(AW),
    .DW(DW),
    .NB(NB)
  ) u_mem (
    .clk_i    (mclk_i),
    .lane_we_i(lane_we),
    .addr_i   (acc_addr),
    .wdata_i  (data_i),
    .rdata_o  (data_o)
  );

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_burst_continue;
    r.pwr_ok && r.st != SBS_IDLE && !start;
  endsequence

  sequence s_write_then_quiet;
    r.st == SBS_WRITE ##0 !start;
  endsequence

  a_sel_deselect: assert property (
    (start && !sel) |=> (r.st == SBS_IDLE && data_oe_n_o)
  ) else $error("deselected strobe did not idle the device");

  a_write_lanes: assert property (
    (lane_we != '0) |-> (!global_write_n_i ? lane_we == '1
      : (!byte_write_gate_n_i && lane_we == ~byte_lane_write_n_i))
  ) else $error("written lanes do not match write controls");

  a_hiz_write: assert property (
    s_write_then_quiet |=> data_oe_n_o
  ) else $error("data bus driven after write without new strobe");

  a_read_drive: assert property (
    (r.pwr_ok && cpu_start && sel && !output_drive_n_i) |=> !data_oe_n_o
  ) else $error("strobed read not driven onto the bus");

  // Held step repeats the address of the access one edge earlier
  a_burst_hold: assert property (
    (s_burst_continue ##0 burst_step_n_i)
      |-> (next_r.cnt == r.cnt && acc_addr == $past(acc_addr))
  ) else $error("burst address moved without advance");

  a_burst_wrap: assert property (
    (s_burst_continue ##0 (!burst_step_n_i && r.cnt == BURST_LAST))
      |=> (r.cnt == BURST_ZERO && $stable(r.base_lo))
  ) else $error("burst did not wrap to first address");

  a_oe_release: assert property (
    output_drive_n_i |=> data_oe_n_o
  ) else $error("bus driven while output drive high");

  a_burst_low_bits: assert property (
    s_burst_continue |=> $stable(r.hi)
  ) else $error("burst changed upper address bits");

  a_power_quiet: assert property (
    !r.pwr_ok |-> (lane_we == '0 && r.st == SBS_IDLE)
  ) else $error("access taken before power-up wait ended");

  a_idle_stays: assert property (
    (r.st == SBS_IDLE && !start) |=> (r.st == SBS_IDLE && data_oe_n_o)
  ) else $error("idle device moved without an accepted strobe");

  a_idle_no_write: assert property (
    (r.st == SBS_IDLE && !start) |-> (lane_we == '0)
  ) else $error("idle device wrote the array");

  a_cpu_read_only: assert property (
    (start && cpu_start && sel) |-> (lane_we == '0)
  ) else $error("processor strobe cycle wrote the array");

  a_ctrl_read_drive: assert property (
    (start && ctrl_start && sel && !wr_req && !output_drive_n_i) |=> !data_oe_n_o
  ) else $error("controller strobed read not driven onto the bus");

  a_full_write: assert property (
    (start && ctrl_start && sel && !global_write_n_i) |-> (lane_we == '1)
  ) else $error("global write did not cover all lanes");

  a_drive_read_only: assert property (
    !data_oe_n_o |-> (r.st == SBS_READ && r.rd_ok)
  ) else $error("bus driven outside an allowed read");

endmodule // sbsram_ctrl
`default_nettype wire

// ==== inc/sbsram_pkg.sv ====
`default_nettype none
package sbsram_pkg;

  // Array shape: 256K words of four 9-bit lanes
  localparam int ADDR_W = 18;
  localparam int DATA_W = 36;
  localparam int LANES  = 4;

  // Burst counter covers the two lowest address bits
  localparam int          BURST_W    = 2;
  localparam logic [1:0]  BURST_ZERO = 2'h0;
  localparam logic [1:0]  BURST_LAST = 2'h3;

  // Power-up wait before the first access
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_POWER_MS    = 1;
  localparam int POWER_UP_CYC  =
    (T_POWER_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Gray coded along idle -> read -> write
  typedef enum logic [1:0] {
    SBS_IDLE  = 2'h0,
    SBS_READ  = 2'h1,
    SBS_WRITE = 2'h3
  } sbsram_state_e;

endpackage
`default_nettype wire

// ==== verilog/sbsram_mem.sv ====
`timescale 1ns/1ns
`default_nettype none
module sbsram_mem #(
  parameter int AW = 18,
  parameter int DW = 36,
  parameter int NB = 4
) (
  input  wire logic          clk_i,
  input  wire logic [NB-1:0] lane_we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output var  logic [DW-1:0] rdata_o
);
  localparam int LW = DW / NB;

  logic [DW-1:0] store [2**AW];

  // Read data registered; a write cycle leaves the last read word in place
  always_ff @(posedge clk_i) begin
    if (lane_we_i == '0) begin
      rdata_o <= store[addr_i];
    end
    for (int i = 0; i < NB; i++) begin
      if (lane_we_i[i]) begin
        store[addr_i][i*LW +: LW] <= wdata_i[i*LW +: LW];
      end
    end
  end

endmodule // sbsram_mem
`default_nettype wire

// ==== testbench/sbs_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module sbs_host (
  input  wire logic        mclk_i,
  input  wire logic [35:0] data_i,
  input  wire logic        oe_n_i,
  output var  logic [35:0] bus_o
);
  logic [35:0] last;
  // Released bus flips every cycle so a stale copy never passes
  always_ff @(posedge mclk_i) last <= bus_o;
  always_comb bus_o = oe_n_i ? ~last : data_i;
endmodule // sbs_host
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import sbsram_pkg::*;
  logic        mclk_i = 1'h0, rst_n_i = 1'h0, cpu_n = 1'h1, ctl_n = 1'h1, step_n = 1'h1;
  logic        sp_n = 1'h0, shd = 1'h1, sld_n = 1'h0, glob_n = 1'h1, bg_n = 1'h1;
  logic        od_n = 1'h0, mode = 1'h0, oe_n;
  logic [3:0]  bl_n = 4'hf;
  logic [17:0] addr = 18'h0, base;
  logic [35:0] din = 36'h0, data_o, bus;
  // Upper bits never move in a burst, so words are kept by their low bits
  logic [35:0] mem [4];
  int          error_cnt = 0, check_count = 0, cyc_cnt = 0, seed = 32'heaae_00de, i;

  sbsram_ctrl #(.POWER_UP_CYC(4)) sbsram_ctrl_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .addr_i(addr), .cpu_addr_strobe_n_i(cpu_n), .ctrl_addr_strobe_n_i(ctl_n),
    .burst_step_n_i(step_n), .burst_interleave_i(mode), .select_primary_n_i(sp_n),
    .select_high_depth_i(shd), .select_low_depth_n_i(sld_n), .global_write_n_i(glob_n),
    .byte_write_gate_n_i(bg_n), .byte_lane_write_n_i(bl_n), .output_drive_n_i(od_n),
    .data_i(din), .data_o(data_o), .data_oe_n_o(oe_n));
  sbs_host sbs_host_i (.mclk_i(mclk_i), .data_i(data_o), .oe_n_i(oe_n), .bus_o(bus));

  initial forever #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (++cyc_cnt > 2000) begin
    error_cnt++;
    report_and_stop();
  end

  task automatic cyc();
    @(posedge mclk_i);
    #1;
  endtask
  task automatic chk_d(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t data %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_f(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t flag %b exp %b", $time, got, exp);
    end
  endtask
  function automatic logic [1:0] ba(input logic [1:0] c);
    return mode ? base[1:0] ^ c : base[1:0] + c;
  endfunction
  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (3) cyc();
    rst_n_i = 1'h1;
    repeat (6) cyc();
    for (int m = 0; m < 2; m++) begin
      mode = m[0];
      base = 18'($random(seed));
      addr = base;
      ctl_n = 1'h0;
      glob_n = 1'h0;
      din = 36'({$random(seed), $random(seed)});
      mem[ba(2'h0)] = din;
      cyc();
      // Remaining burst words through the byte gate with every lane low
      ctl_n = 1'h1;
      glob_n = 1'h1;
      bg_n = 1'h0;
      bl_n = 4'h0;
      step_n = 1'h0;
      for (i = 1; i < 4; i++) begin
        din = 36'({$random(seed), $random(seed)});
        mem[ba(2'(i))] = din;
        cyc();
      end
      // Wrapped step lands on the first word: patch a random set of lanes
      bl_n = 4'($random(seed));
      din = 36'({$random(seed), $random(seed)});
      for (int l = 0; l < 4; l++) begin
        if (!bl_n[l]) begin
          mem[ba(2'h0)][l*9 +: 9] = din[l*9 +: 9];
        end
      end
      cyc();
      bg_n = 1'h1;
      bl_n = 4'hf;
      step_n = 1'h1;
      cyc();
      chk_f(oe_n, 1'h1);
      chk_d(data_o, mem[ba(2'h0)]);
      // Restart one word further on so the burst order really matters
      base[1:0] = base[1:0] + 2'h1;
      addr = base;
      cpu_n = 1'h0;
      cyc();
      chk_f(oe_n, 1'h0);
      chk_d(bus, mem[ba(2'h0)]);
      cpu_n = 1'h1;
      for (i = 0; i < 5; i++) begin
        step_n = (i == 1);
        cyc();
        chk_d(data_o, mem[ba(2'(i < 1 ? 1 : i))]);
      end
      od_n = 1'h1;
      cyc();
      chk_f(oe_n, 1'h1);
      od_n = 1'h0;
    end
    for (i = 0; i < 3; i++) begin
      // Odd passes open the read with the controller strobe instead
      {cpu_n, ctl_n} = i[0] ? 2'h2 : 2'h1;
      cyc();
      chk_f(oe_n, 1'h0);
      {cpu_n, ctl_n} = 2'h2;
      {sp_n, shd, sld_n} = 3'h2 ^ (3'h4 >> i);
      cyc();
      chk_f(oe_n, 1'h1);
      {sp_n, shd, sld_n} = 3'h2;
    end
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
